/* core/tcc8_timer.sv */
// 8-bit timer/counter with two compare units, waveform outputs and flags

module tcc8_timer
    import tcc8_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // external count pin
    input wire logic external_count_input,
    // compare output pins
    output logic compare_a_output,
    output logic compare_a_output_en,
    output logic compare_b_output,
    output logic compare_b_output_en,
    // interrupt requests and acknowledges
    output logic overflow_irq,
    output logic compare_a_irq,
    output logic compare_b_irq,
    input wire logic overflow_irq_ack,
    input wire logic compare_a_irq_ack,
    input wire logic compare_b_irq_ack
);

    // software-visible registers and counter state
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic dir_down_r;
    logic dir_down_nxt;
    logic [2:0] flag_r;
    logic [2:0] mask_r;

    // clock select and bus side state
    logic [9:0] prescale_r;
    logic ext_prev_r;
    logic block_r;
    logic [7:0] rdata_r;

    // per-unit compare state, index 0 is unit A
    logic [7:0] cmp_work_r [2];
    logic [7:0] cmp_buf_r [2];
    logic out_r [2];
    logic out_en [2];

    // decoded strobes, events and indications
    logic [1:0] match;
    logic [1:0] cmp_event;
    logic [2:0] wave_mode;
    logic [2:0] clk_sel;
    logic [2:0] flag_event;
    logic [2:0] irq_ack;
    logic tick;
    logic is_pwm;
    logic is_fast;
    logic is_phase;
    logic [7:0] top_val;
    logic at_top;
    logic at_bottom;
    logic ovf_event;
    logic upd_event;
    logic count_wr;

    // decoded control fields
    assign wave_mode = {ctrl_b_r[TCC8_CB_WGM2], ctrl_a_r[TCC8_CA_WGM1], ctrl_a_r[TCC8_CA_WGM0]};
    assign clk_sel = ctrl_b_r[TCC8_CB_CS_LO +: 3];
    assign is_pwm = wave_mode[0];
    assign is_fast = (wave_mode[1:0] == 2'h3);
    assign is_phase = (wave_mode[1:0] == 2'h1);
    assign count_wr = reg_wr && (reg_addr == TCC8_OFF_COUNT);

    // top of the sequence and the extreme indications
    assign top_val = (is_pwm && wave_mode[2]) ? cmp_work_r[0] : TCC8_MAX;
    assign at_top = (count_r == top_val);
    assign at_bottom = (count_r == TCC8_BOTTOM);

    // free running prescaler; taps shared by all divided sources
    // it is never cleared on a select change, so the first divided tick may come early
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prescale_r <= 10'h000;
        end else begin
            prescale_r <= prescale_r + TCC8_PS_ONE;
        end
    end

    // previous external pin level for edge selection
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= external_count_input;
        end
    end

    // clock select: source and active edge form the timer tick
    always_comb begin
        case (clk_sel)
            TCC8_CS_NONE: tick = 1'b0;
            TCC8_CS_DIV1: tick = 1'b1;
            TCC8_CS_DIV8: tick = ((prescale_r & TCC8_PS_MASK8) == TCC8_PS_MASK8);
            TCC8_CS_DIV64: tick = ((prescale_r & TCC8_PS_MASK64) == TCC8_PS_MASK64);
            TCC8_CS_DIV256: tick = ((prescale_r & TCC8_PS_MASK256) == TCC8_PS_MASK256);
            TCC8_CS_DIV1024: tick = ((prescale_r & TCC8_PS_MASK1024) == TCC8_PS_MASK1024);
            TCC8_CS_EXT_FALL: tick = ext_prev_r && !external_count_input;
            TCC8_CS_EXT_RISE: tick = !ext_prev_r && external_count_input;
            default: tick = 1'b0;
        endcase
    end

    // counting sequence per waveform mode, evaluated on each tick
    always_comb begin
        count_nxt = count_r;
        dir_down_nxt = dir_down_r;
        ovf_event = 1'b0;
        upd_event = 1'b0;
        if (tick) begin
            case (wave_mode)
                TCC8_MODE_PHASE_MAX, TCC8_MODE_PHASE_CMP: begin
                    if (!dir_down_r) begin
                        if (at_top) begin
                            dir_down_nxt = 1'b1;
                            count_nxt = count_r - 8'h01;
                            upd_event = 1'b1;
                        end else begin
                            count_nxt = count_r + 8'h01;
                        end
                    end else begin
                        if (at_bottom) begin
                            dir_down_nxt = 1'b0;
                            count_nxt = count_r + 8'h01;
                            ovf_event = 1'b1;
                        end else begin
                            count_nxt = count_r - 8'h01;
                        end
                    end
                end
                TCC8_MODE_FAST_MAX, TCC8_MODE_FAST_CMP: begin
                    if (at_top) begin
                        count_nxt = TCC8_BOTTOM;
                        ovf_event = 1'b1;
                        upd_event = 1'b1;
                    end else begin
                        count_nxt = count_r + 8'h01;
                    end
                end
                TCC8_MODE_CTC: begin
                    // overflow whenever the count leaves the maximum: a compare at the maximum, or an out-of-range compare that lets it wrap
                    ovf_event = (count_r == TCC8_MAX);
                    if (match[0]) begin
                        count_nxt = TCC8_BOTTOM;
                    end else begin
                        count_nxt = count_r + 8'h01;
                    end
                end
                default: begin
                    // normal and reserved codes count up and wrap
                    count_nxt = count_r + 8'h01;
                    ovf_event = (count_r == TCC8_MAX);
                end
            endcase
        end
    end

    // counter register; a software write takes precedence over counting
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            count_r <= TCC8_RST_BYTE;
            dir_down_r <= 1'b0;
        end else begin
            // direction is left alone by a counter write
            dir_down_r <= dir_down_nxt;
            if (count_wr) begin
                count_r <= reg_wdata;
            end else begin
                count_r <= count_nxt;
            end
        end
    end

    // match blocking after a counter write, held until the next tick
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            block_r <= 1'b0;
        end else if (count_wr) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end

    // control registers; force strobes are not stored
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_a_r <= TCC8_RST_BYTE;
            ctrl_b_r <= TCC8_RST_BYTE;
            mask_r <= TCC8_RST_BITS;
        end else if (reg_wr) begin
            if (reg_addr == TCC8_OFF_CTRL_A) begin
                ctrl_a_r <= reg_wdata;
            end
            if (reg_addr == TCC8_OFF_CTRL_B) begin
                ctrl_b_r <= reg_wdata & TCC8_CB_STORE_MASK;
            end
            if (reg_addr == TCC8_OFF_MASK) begin
                mask_r <= reg_wdata[2:0];
            end
        end
    end

    // compare units A and B share the counter
    for (genvar i = 0; i < 2; i++) begin : g_cmp
        localparam logic [2:0] OFF = (i == 0) ? TCC8_OFF_CMP_A : TCC8_OFF_CMP_B;
        localparam int unsigned ACT_LO = (i == 0) ? TCC8_CA_ACT_A_LO : TCC8_CA_ACT_B_LO;
        localparam int unsigned FORCE_BIT = (i == 0) ? TCC8_CB_FORCE_A : TCC8_CB_FORCE_B;
        logic [1:0] action;
        logic force_cmp;
        logic match_lvl;
        logic cmp_at_top;
        logic cmp_at_bottom;

        assign action = ctrl_a_r[ACT_LO +: 2];
        assign match[i] = (count_r == cmp_work_r[i]);
        assign cmp_event[i] = tick && match[i] && !block_r;
        assign force_cmp = reg_wr && (reg_addr == TCC8_OFF_CTRL_B) && reg_wdata[FORCE_BIT] && !is_pwm;
        assign match_lvl = action[0];
        assign cmp_at_top = (cmp_work_r[i] == top_val);
        assign cmp_at_bottom = (cmp_work_r[i] == TCC8_BOTTOM);

        // buffer and working value; PWM updates wait for the turn point
        always_ff @(posedge core_clk) begin
            if (!rst_b) begin
                cmp_buf_r[i] <= TCC8_RST_BYTE;
                cmp_work_r[i] <= TCC8_RST_BYTE;
            end else begin
                if (reg_wr && (reg_addr == OFF)) begin
                    cmp_buf_r[i] <= reg_wdata;
                end
                if (!is_pwm) begin
                    if (reg_wr && (reg_addr == OFF)) begin
                        cmp_work_r[i] <= reg_wdata;
                    end
                end else if (upd_event) begin
                    cmp_work_r[i] <= cmp_buf_r[i];
                end
            end
        end

        // waveform generator; a force acts like a match without the flag
        always_ff @(posedge core_clk) begin
            if (!rst_b) begin
                out_r[i] <= 1'b0;
            end else if (!is_pwm) begin
                if (cmp_event[i] || force_cmp) begin
                    case (action)
                        TCC8_ACT_TOGGLE: out_r[i] <= !out_r[i];
                        TCC8_ACT_CLEAR: out_r[i] <= 1'b0;
                        TCC8_ACT_SET: out_r[i] <= 1'b1;
                        default: out_r[i] <= out_r[i];
                    endcase
                end
            end else if (tick && action[1]) begin
                if (is_fast && at_top) begin
                    // compare at top would leave a one-tick spike, so hold the match level
                    out_r[i] <= cmp_at_top ? match_lvl : !match_lvl;
                end else if (is_phase && at_top && !dir_down_r && cmp_at_top) begin
                    out_r[i] <= !match_lvl;
                end else if (is_phase && at_bottom && dir_down_r && cmp_at_bottom) begin
                    out_r[i] <= match_lvl;
                end else if (cmp_event[i]) begin
                    out_r[i] <= (is_phase && dir_down_r) ? !match_lvl : match_lvl;
                end
            end else if (cmp_event[i] && (action == TCC8_ACT_TOGGLE) && (i == 0) && wave_mode[2]) begin
                out_r[i] <= !out_r[i];
            end
        end

        // pin override; toggle in PWM is only meaningful for unit A with compare top
        assign out_en[i] = (action != TCC8_ACT_OFF) &&
            !(is_pwm && (action == TCC8_ACT_TOGGLE) && !((i == 0) && wave_mode[2]));
    end

    assign compare_a_output = out_r[0];
    assign compare_b_output = out_r[1];
    assign compare_a_output_en = out_en[0];
    assign compare_b_output_en = out_en[1];

    // flag events and clears, indexed by flag bit position
    assign flag_event[TCC8_FLAG_OVF] = ovf_event;
    assign flag_event[TCC8_FLAG_CMP_A] = cmp_event[0];
    assign flag_event[TCC8_FLAG_CMP_B] = cmp_event[1];
    // one acknowledge pulse per executed request
    assign irq_ack[TCC8_FLAG_OVF] = overflow_irq_ack;
    assign irq_ack[TCC8_FLAG_CMP_A] = compare_a_irq_ack;
    assign irq_ack[TCC8_FLAG_CMP_B] = compare_b_irq_ack;

    // sticky flags; a set in the clearing cycle survives the clear
    for (genvar k = 0; k < 3; k++) begin : g_flag
        always_ff @(posedge core_clk) begin
            if (!rst_b) begin
                flag_r[k] <= 1'b0;
            end else if (flag_event[k]) begin
                flag_r[k] <= 1'b1;
            end else if (irq_ack[k]) begin
                flag_r[k] <= 1'b0;
            end else if (reg_wr && (reg_addr == TCC8_OFF_FLAG) && reg_wdata[k]) begin
                flag_r[k] <= 1'b0;
            end
        end
    end

    // masked requests
    assign overflow_irq = flag_r[TCC8_FLAG_OVF] && mask_r[TCC8_FLAG_OVF];
    assign compare_a_irq = flag_r[TCC8_FLAG_CMP_A] && mask_r[TCC8_FLAG_CMP_A];
    assign compare_b_irq = flag_r[TCC8_FLAG_CMP_B] && mask_r[TCC8_FLAG_CMP_B];

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_r <= TCC8_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                TCC8_OFF_CTRL_A: rdata_r <= ctrl_a_r;
                TCC8_OFF_CTRL_B: rdata_r <= ctrl_b_r;
                TCC8_OFF_COUNT: rdata_r <= count_r;
                TCC8_OFF_CMP_A: rdata_r <= is_pwm ? cmp_buf_r[0] : cmp_work_r[0];
                TCC8_OFF_CMP_B: rdata_r <= is_pwm ? cmp_buf_r[1] : cmp_work_r[1];
                TCC8_OFF_FLAG: rdata_r <= {5'h00, flag_r};
                TCC8_OFF_MASK: rdata_r <= {5'h00, mask_r};
                default: rdata_r <= TCC8_RST_BYTE;
            endcase
        end else begin
            rdata_r <= TCC8_RST_BYTE;
        end
    end

    // registered so the answer stands exactly one cycle
    assign reg_rdata = rdata_r;

endmodule : tcc8_timer

/* dv/tcc8_assertions.sv */
// port-level checks for the 8-bit timer/counter
module tcc8_assertions
    import tcc8_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // compare pins
    input wire logic compare_a_output,
    input wire logic compare_a_output_en,
    input wire logic compare_b_output,
    input wire logic compare_b_output_en,
    // requests and acknowledges
    input wire logic overflow_irq,
    input wire logic compare_a_irq,
    input wire logic compare_b_irq,
    input wire logic overflow_irq_ack,
    input wire logic compare_a_irq_ack,
    input wire logic compare_b_irq_ack
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // one write or read strobe at a given offset
    sequence s_wr(logic [2:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_rd(logic [2:0] a);
        reg_rd && reg_addr == a;
    endsequence

    // a read straight after a write returns the written byte
    property p_back(logic [2:0] a);
        s_wr(a) ##1 s_rd(a) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty

    // a request only drops through its ack, a flag clear or a mask write
    property p_drop(logic irq, logic ack, logic bit_one);
        $fell(irq) |-> $past(ack) ||
            $past(reg_wr && (reg_addr == TCC8_OFF_MASK || (reg_addr == TCC8_OFF_FLAG && bit_one)));
    endproperty

    // action code zero gives the pin back to the port
    property p_off(logic [1:0] act, logic en);
        s_wr(TCC8_OFF_CTRL_A) ##0 act == TCC8_ACT_OFF |=> !en;
    endproperty

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside the read answer");
    a_unmapped_zero: assert property (s_rd(3'h7) |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_reset_clean: assert property ($rose(rst_b) |-> {reg_rdata, overflow_irq, compare_a_irq, compare_b_irq,
        compare_a_output, compare_b_output, compare_a_output_en, compare_b_output_en} == 15'h0000)
        else $error("outputs not cleared by reset");
    a_count_back: assert property (p_back(TCC8_OFF_COUNT))
        else $error("counter readback differs from write");
    a_cmpa_back: assert property (p_back(TCC8_OFF_CMP_A))
        else $error("compare A readback differs from write");
    a_cmpb_back: assert property (p_back(TCC8_OFF_CMP_B))
        else $error("compare B readback differs from write");
    a_ovf_drop: assert property (p_drop(overflow_irq, overflow_irq_ack, reg_wdata[TCC8_FLAG_OVF]))
        else $error("overflow request dropped without cause");
    a_cmpa_drop: assert property (p_drop(compare_a_irq, compare_a_irq_ack, reg_wdata[TCC8_FLAG_CMP_A]))
        else $error("compare A request dropped without cause");
    a_cmpb_drop: assert property (p_drop(compare_b_irq, compare_b_irq_ack, reg_wdata[TCC8_FLAG_CMP_B]))
        else $error("compare B request dropped without cause");
    a_a_pin_off: assert property (p_off(reg_wdata[7:6], compare_a_output_en))
        else $error("unit A still drives pin with action off");
    a_b_pin_off: assert property (p_off(reg_wdata[5:4], compare_b_output_en))
        else $error("unit B still drives pin with action off");
endmodule : tcc8_assertions

bind tcc8_timer tcc8_assertions u_chk (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .compare_a_output(compare_a_output), .compare_a_output_en(compare_a_output_en),
    .compare_b_output(compare_b_output), .compare_b_output_en(compare_b_output_en),
    .overflow_irq(overflow_irq), .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
    .overflow_irq_ack(overflow_irq_ack), .compare_a_irq_ack(compare_a_irq_ack),
    .compare_b_irq_ack(compare_b_irq_ack));

/* dv/testbench.sv */
// self-checking bench for the 8-bit timer/counter
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import tcc8_pkg::*;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ext_pin = 1'b0;
    logic [2:0] ack = 3'h0; // overflow, A, B
    logic [7:0] reg_rdata;
    logic oa, oa_en, ob, ob_en, irq_o, irq_a, irq_b, lvl;
    int fail_count = 0;
    int checked = 0;
    // count after 1024 core clock edges of each prescaler setting
    logic [7:0] tick_exp [6] = '{8'h00, 8'h00, 8'h80, 8'h10, 8'h04, 8'h01};

    tcc8_timer DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_count_input(ext_pin),
        .compare_a_output(oa), .compare_a_output_en(oa_en), .compare_b_output(ob), .compare_b_output_en(ob_en),
        .overflow_irq(irq_o), .compare_a_irq(irq_a), .compare_b_irq(irq_b), .overflow_irq_ack(ack[0]),
        .compare_a_irq_ack(ack[1]), .compare_b_irq_ack(ack[2]));

    // 200 MHz core clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic close_out();
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // write strobe; returns in the time step of the edge that takes it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read strobe, answer looked at in the one cycle it stands
    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rc

    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, d);
    endtask : wr_rd

    task automatic ack_pulse(input int i);
        @(posedge core_clk);
        ack[i] <= 1'b1;
        @(posedge core_clk);
        ack[i] <= 1'b0;
    endtask : ack_pulse

    // settle just after the n-th following edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    // cut a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rc(i[2:0], 8'h00);
        chk({1'b0, irq_o, irq_a, irq_b, oa, oa_en, ob, ob_en}, 8'h00);
        wr(TCC8_OFF_MASK, 8'h07);
        // every prescaler tap over a window of 1024 edges
        for (int i = 1; i < 6; i++) begin
            wr(TCC8_OFF_CTRL_B, 8'h00);
            wr(TCC8_OFF_COUNT, 8'h00);
            wr(TCC8_OFF_CTRL_B, i[7:0]);
            repeat (1023) @(posedge core_clk);
            rc(TCC8_OFF_COUNT, tick_exp[i]);
        end
        wr(TCC8_OFF_CTRL_B, 8'h00);
        wr_rd(TCC8_OFF_COUNT, 8'h10);
        repeat (20) @(posedge core_clk);
        rc(TCC8_OFF_COUNT, 8'h10);
        // normal mode wrap sets overflow six ticks after the write
        wr(TCC8_OFF_FLAG, 8'h07);
        wr(TCC8_OFF_CTRL_B, {5'h00, TCC8_CS_DIV1});
        wr(TCC8_OFF_COUNT, 8'hFA);
        wait_cyc(5);
        chk({7'h00, irq_o}, 8'h00);
        wait_cyc(1);
        chk({7'h00, irq_o}, 8'h01);
        rc(TCC8_OFF_COUNT, 8'h01);
        wr(TCC8_OFF_FLAG, 8'h00);
        wait_cyc(1);
        chk({7'h00, irq_o}, 8'h01);
        wr(TCC8_OFF_FLAG, 8'h01);
        wait_cyc(1);
        chk({7'h00, irq_o}, 8'h00);
        wr(TCC8_OFF_CTRL_B, 8'h00);
        // counter written to match A while stopped: first tick's match is dropped
        wr_rd(TCC8_OFF_CMP_A, 8'h20);
        wr(TCC8_OFF_CMP_B, 8'h21);
        wr(TCC8_OFF_COUNT, 8'h20);
        wr(TCC8_OFF_FLAG, 8'h07);
        wr(TCC8_OFF_CTRL_B, {5'h00, TCC8_CS_DIV1});
        wait_cyc(1);
        chk({6'h00, irq_a, irq_b}, 8'h00);
        wait_cyc(1);
        chk({6'h00, irq_a, irq_b}, 8'h01);
        wr(TCC8_OFF_CTRL_B, 8'h00);
        ack_pulse(2);
        wait_cyc(1);
        chk({7'h00, irq_b}, 8'h00);
        // clear-on-compare with top five, unit A toggling
        wr(TCC8_OFF_CTRL_A, 8'h42);
        wait_cyc(0);
        chk({6'h00, oa_en, ob_en}, 8'h02);
        wr(TCC8_OFF_CMP_A, 8'h05);
        wr(TCC8_OFF_COUNT, 8'h00);
        wr(TCC8_OFF_FLAG, 8'h07);
        wr(TCC8_OFF_CTRL_B, {5'h00, TCC8_CS_DIV1});
        wait_cyc(5);
        chk({7'h00, irq_a}, 8'h00);
        wait_cyc(1);
        chk({7'h00, irq_a}, 8'h01);
        rc(TCC8_OFF_COUNT, 8'h01);
        lvl = oa;
        wait_cyc(6);
        chk({7'h00, oa}, {7'h00, ~lvl});
        wr(TCC8_OFF_CTRL_B, 8'h00);
        ack_pulse(1);
        wait_cyc(1);
        chk({7'h00, irq_a}, 8'h00);
        // fast mode: new compare B waits in its buffer until the wrap
        wr(TCC8_OFF_CTRL_A, {5'h00, TCC8_MODE_FAST_MAX});
        wr_rd(TCC8_OFF_CMP_B, 8'h40);
        wr(TCC8_OFF_COUNT, 8'h3E);
        wr(TCC8_OFF_FLAG, 8'h07);
        wr(TCC8_OFF_CTRL_B, {5'h00, TCC8_CS_DIV1});
        wait_cyc(3);
        chk({7'h00, irq_b}, 8'h00);
        wait_cyc(190);
        chk({7'h00, irq_o}, 8'h00);
        wait_cyc(1);
        chk({7'h00, irq_o}, 8'h01);
        wait_cyc(64);
        chk({7'h00, irq_b}, 8'h00);
        wait_cyc(1);
        chk({7'h00, irq_b}, 8'h01);
        wr(TCC8_OFF_CTRL_B, 8'h00);
        // phase correct: turn at the maximum, overflow at the bottom while counting down
        wr(TCC8_OFF_CTRL_A, {5'h00, TCC8_MODE_PHASE_MAX});
        wr(TCC8_OFF_COUNT, 8'hFD);
        wr(TCC8_OFF_FLAG, 8'h07);
        wr(TCC8_OFF_CTRL_B, {5'h00, TCC8_CS_DIV1});
        wait_cyc(257);
        chk({7'h00, irq_o}, 8'h00);
        wait_cyc(1);
        chk({7'h00, irq_o}, 8'h01);
        rc(TCC8_OFF_COUNT, 8'h02);
        ack_pulse(0);
        wait_cyc(1);
        chk({7'h00, irq_o}, 8'h00);
        wr(TCC8_OFF_CTRL_B, 8'h00);
        wr(TCC8_OFF_CTRL_A, 8'h00);
        // external pin, rising then falling edges
        wr(TCC8_OFF_COUNT, 8'h00);
        for (int j = 0; j < 2; j++) begin
            wr(TCC8_OFF_CTRL_B, (j == 0) ? {5'h00, TCC8_CS_EXT_RISE} : {5'h00, TCC8_CS_EXT_FALL});
            for (int i = 0; i < 6; i++) begin
                @(posedge core_clk);
                ext_pin <= ~ext_pin;
                repeat (3) @(posedge core_clk);
            end
            rc(TCC8_OFF_COUNT, (j == 0) ? 8'h03 : 8'h06);
        end
        // force strobe in normal mode sets unit B's pin but not its flag
        wr(TCC8_OFF_CTRL_A, 8'h30);
        wr(TCC8_OFF_FLAG, 8'h07);
        wr(TCC8_OFF_CTRL_B, 8'h40);
        wait_cyc(0);
        chk({5'h00, ob, ob_en, irq_b}, 8'h06);
        close_out();
    end
endmodule : testbench

/* inc/tcc8_pkg.sv */
// constants shared by the 8-bit timer/counter with two compare units
package tcc8_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] TCC8_OFF_CTRL_A = 3'h0;
    localparam logic [2:0] TCC8_OFF_CTRL_B = 3'h1;
    localparam logic [2:0] TCC8_OFF_COUNT = 3'h2;
    localparam logic [2:0] TCC8_OFF_CMP_A = 3'h3;
    localparam logic [2:0] TCC8_OFF_CMP_B = 3'h4;
    localparam logic [2:0] TCC8_OFF_FLAG = 3'h5;
    localparam logic [2:0] TCC8_OFF_MASK = 3'h6;

    // timer_control_a fields
    localparam int unsigned TCC8_CA_WGM0 = 0;
    localparam int unsigned TCC8_CA_WGM1 = 1;
    localparam int unsigned TCC8_CA_ACT_B_LO = 4;
    localparam int unsigned TCC8_CA_ACT_A_LO = 6;

    // timer_control_b fields
    localparam int unsigned TCC8_CB_CS_LO = 0;
    localparam int unsigned TCC8_CB_WGM2 = 3;
    localparam int unsigned TCC8_CB_FORCE_B = 6;
    localparam int unsigned TCC8_CB_FORCE_A = 7;
    localparam logic [7:0] TCC8_CB_STORE_MASK = 8'h0F;

    // flag and mask bit positions
    localparam int unsigned TCC8_FLAG_OVF = 0;
    localparam int unsigned TCC8_FLAG_CMP_A = 1;
    localparam int unsigned TCC8_FLAG_CMP_B = 2;

    // counter extremes and reset values
    localparam logic [7:0] TCC8_BOTTOM = 8'h00;
    localparam logic [7:0] TCC8_MAX = 8'hFF;
    localparam logic [7:0] TCC8_RST_BYTE = 8'h00;
    localparam logic [2:0] TCC8_RST_BITS = 3'h0;

    // clock source select codes
    localparam logic [2:0] TCC8_CS_NONE = 3'h0;
    localparam logic [2:0] TCC8_CS_DIV1 = 3'h1;
    localparam logic [2:0] TCC8_CS_DIV8 = 3'h2;
    localparam logic [2:0] TCC8_CS_DIV64 = 3'h3;
    localparam logic [2:0] TCC8_CS_DIV256 = 3'h4;
    localparam logic [2:0] TCC8_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TCC8_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TCC8_CS_EXT_RISE = 3'h7;

    // prescaler tap masks: tick when all masked bits are ones
    localparam logic [9:0] TCC8_PS_MASK8 = 10'h007;
    localparam logic [9:0] TCC8_PS_MASK64 = 10'h03F;
    localparam logic [9:0] TCC8_PS_MASK256 = 10'h0FF;
    localparam logic [9:0] TCC8_PS_MASK1024 = 10'h3FF;
    localparam logic [9:0] TCC8_PS_ONE = 10'h001;

    // waveform mode codes
    localparam logic [2:0] TCC8_MODE_NORMAL = 3'h0;
    localparam logic [2:0] TCC8_MODE_PHASE_MAX = 3'h1;
    localparam logic [2:0] TCC8_MODE_CTC = 3'h2;
    localparam logic [2:0] TCC8_MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] TCC8_MODE_PHASE_CMP = 3'h5;
    localparam logic [2:0] TCC8_MODE_FAST_CMP = 3'h7;

    // compare output action codes
    localparam logic [1:0] TCC8_ACT_OFF = 2'h0;
    localparam logic [1:0] TCC8_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TCC8_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TCC8_ACT_SET = 2'h3;

endpackage : tcc8_pkg
